// *** ccl_consts.svh ***
`ifndef CCL_CONSTS_SVH
`define CCL_CONSTS_SVH
// ----------------------------------------------------------------------
// Bus address and command codes
// ----------------------------------------------------------------------
`define CCL_SMB_ADDR      7'h09
`define CCL_CMD_CHG       8'h14
`define CCL_CMD_INP2      8'h3b
`define CCL_CMD_INP1      8'h3f
// ----------------------------------------------------------------------
// Ceiling field layout, clamp and reset values
// ----------------------------------------------------------------------
`define CCL_FIELD_MASK    16'h1ffc
`define CCL_CEIL_MAX      16'h17c0
`define CCL_CHG_RST       16'h0000
`define CCL_INP1_RST      16'h0000
`define CCL_INP2_DFLT     16'h05dc
`define CCL_STRAP_W       11
// ----------------------------------------------------------------------
// Synchroniser lanes
// ----------------------------------------------------------------------
`define CCL_IX_SCL        0
`define CCL_IX_SDA        1
`define CCL_IX_APOR       2
`define CCL_IX_BATF       3
`define CCL_IX_CHALF      4
`define CCL_IX_IHALF      5
`define CCL_IX_STRAP      6
`define CCL_SYNC_W        17
// Idle level per lane: both bus lines rest high on their pull-ups
`define CCL_SYNC_IDLE     17'h00003
`endif

// *** ccl_pkg.sv ***
// ----------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------
package ccl_pkg;
	// Serial slave protocol states
	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_cmd,
		st_wlo,
		st_whi,
		st_ack_addr,
		st_ack_cmd,
		st_ack_wlo,
		st_ack_whi,
		st_rlo,
		st_rhi,
		st_mack_lo,
		st_mack_hi
	} ccl_state_t;
	// One register word
	typedef logic [15:0] ccl_word_t;
endpackage : ccl_pkg

// *** ccl_pin_if.sv ***
// ----------------------------------------------------------------------
// Synchronised pin levels and their edges
// ----------------------------------------------------------------------
interface ccl_pin_if #(
	parameter int W = 17
);
	logic [W-1:0] lvl;  // Filtered level
	logic [W-1:0] rise; // One-cycle rise pulse
	logic [W-1:0] fall; // One-cycle fall pulse
	modport src (output lvl, output rise, output fall);
	modport snk (input lvl, input rise, input fall);
endinterface : ccl_pin_if

// *** ccl_pin_sync.sv ***
// ----------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------
module ccl_pin_sync #(
	parameter int           W    = 17,
	parameter logic [W-1:0] IDLE = '0 // Idle level of each lane, used as its reset level
) (
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] raw_i,
	ccl_pin_if.src            pins
);
	import ccl_pkg::*;

	// Refuse widths the lanes cannot serve
	if (W < 1) begin : g_bad_w
		$error("ccl_pin_sync: W must be at least one");
	end

	// One lane per bit; a level counts only once stages two and three agree,
	// which rejects a single-cycle glitch on slow bus edges
	for (genvar i = 0; i < W; i++) begin : g_lane
		logic s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
		logic nxt_lvl, nxt_rise, nxt_fall;
		// Filter decision and edge pulses
		always_comb begin
			nxt_lvl  = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
			nxt_rise = nxt_lvl & ~lvl_ff;
			nxt_fall = ~nxt_lvl & lvl_ff;
		end
		// Stage registers; stage one feeds stage two only. Reset to the idle
		// level, or the first cycles after reset would show a false edge
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				s1_ff   <= IDLE[i];
				s2_ff   <= IDLE[i];
				s3_ff   <= IDLE[i];
				lvl_ff  <= IDLE[i];
				rise_ff <= 1'b0;
				fall_ff <= 1'b0;
			end else begin
				s1_ff   <= raw_i[i];
				s2_ff   <= s1_ff;
				s3_ff   <= s2_ff;
				lvl_ff  <= nxt_lvl;
				rise_ff <= nxt_rise;
				fall_ff <= nxt_fall;
			end
		end
		assign pins.lvl[i]  = lvl_ff;
		assign pins.rise[i] = rise_ff;
		assign pins.fall[i] = fall_ff;
	end
endmodule : ccl_pin_sync

// *** ccl_ceiling_regs.sv ***
// Operation
// - Word read/write slave at fixed address only
// - Charge ceiling keeps only bits 12:2
// - Charge ceiling clamped to 6080mA code
// - Charge bit 2 weighs 4mA, doubling upward
// - Half sense resistor doubles charge weights
// - Reset clears charge ceiling to zero
// - Charge ceiling reads back stored value
// - Input ceilings keep only bits 12:2
// - Input ceilings clamped to 6080mA code
// - Input bit 2 weighs 4mA, doubling upward
// - Half sense resistor doubles input weights
// - Adapter reset loads primary from strap
// - Adapter reset defaults secondary unless battery first
// - Input ceilings read back stored values
// - Secondary masked, clamped and read back exactly like primary
`include "ccl_consts.svh"

module ccl_ceiling_regs (
	input  wire logic                    clock_i,
	input  wire logic                    nrst_i,
	input  wire logic                    scl_i,
	input  wire logic                    sda_i,
	output logic                         sda_o,
	output logic                         sda_oe_o,
	input  wire logic                    adapter_por_i,
	input  wire logic                    battery_first_i,
	input  wire logic                    charge_half_rsense_i,
	input  wire logic                    input_half_rsense_i,
	input  wire logic [`CCL_STRAP_W-1:0] strap_resistor_pin_code_i,
	output logic [10:0]                  charge_code_o,
	output logic [10:0]                  input_primary_code_o,
	output logic [10:0]                  input_secondary_code_o,
	output logic [13:0]                  charge_ma_o,
	output logic [13:0]                  input_primary_ma_o,
	output logic [13:0]                  input_secondary_ma_o
);
	import ccl_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	logic [`CCL_SYNC_W-1:0] raw_vec; // All outside inputs, one lane each

	assign raw_vec = {strap_resistor_pin_code_i, input_half_rsense_i, charge_half_rsense_i,
		battery_first_i, adapter_por_i, sda_i, scl_i};

	ccl_pin_if #(.W(`CCL_SYNC_W)) pins ();

	ccl_pin_sync #(.W(`CCL_SYNC_W), .IDLE(`CCL_SYNC_IDLE)) u_sync (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.raw_i   (raw_vec),
		.pins    (pins.src)
	);

	logic                    sda_lvl;    // Filtered data line
	logic                    scl_rise;   // Clock line rose
	logic                    scl_fall;   // Clock line fell
	logic                    bus_start;  // Data fell while clock high
	logic                    bus_stop;   // Data rose while clock high
	logic                    adp_evt;    // Adapter reset released
	logic [`CCL_STRAP_W-1:0] strap_code; // Decoded strap value

	assign sda_lvl    = pins.lvl[`CCL_IX_SDA];
	assign scl_rise   = pins.rise[`CCL_IX_SCL];
	assign scl_fall   = pins.fall[`CCL_IX_SCL];
	assign bus_start  = pins.fall[`CCL_IX_SDA] & pins.lvl[`CCL_IX_SCL];
	assign bus_stop   = pins.rise[`CCL_IX_SDA] & pins.lvl[`CCL_IX_SCL];
	assign adp_evt    = pins.fall[`CCL_IX_APOR];
	assign strap_code = pins.lvl[`CCL_IX_STRAP +: `CCL_STRAP_W];

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Mask to the ceiling field, then clamp to the largest legal code
	function automatic ccl_word_t ccl_fold(input ccl_word_t w);
		ccl_word_t m;
		m = w & `CCL_FIELD_MASK;
		ccl_fold = (m > `CCL_CEIL_MAX) ? `CCL_CEIL_MAX : m;
	endfunction : ccl_fold

	// Register value already equals mA for the nominal resistor; a half
	// resistor doubles every weight
	function automatic logic [13:0] ccl_ma(input ccl_word_t r, input logic half);
		ccl_ma = half ? {r[12:0], 1'b0} : {1'b0, r[12:0]};
	endfunction : ccl_ma

	// ------------------------------------------------------------------
	// Serial slave state
	// ------------------------------------------------------------------
	ccl_state_t st_ff, nxt_st;         // Protocol phase
	logic [3:0] bitcnt_ff, nxt_bitcnt; // Bits seen in this byte
	logic [7:0] sh_ff, nxt_sh;         // Shift register, in or out
	logic [7:0] cmd_ff, nxt_cmd;       // Last command code
	logic [7:0] lo_ff, nxt_lo;         // Held low data byte
	logic       rw_ff, nxt_rw;         // Read bit of the address
	logic       oe_ff, nxt_oe;         // Pulling the data line low
	logic       sdo_ff;                // Open-drain output level
	logic       wr_stb;                // Whole word received
	ccl_word_t  wr_word;               // Word being committed
	ccl_word_t  rd_word;               // Word selected for read

	ccl_word_t  chg_ff, nxt_chg;       // Charge ceiling
	ccl_word_t  inp1_ff, nxt_inp1;     // Primary input ceiling
	ccl_word_t  inp2_ff, nxt_inp2;     // Secondary input ceiling

	// Read selection; unmapped commands read as zero
	always_comb begin
		case (cmd_ff)
			`CCL_CMD_CHG:  rd_word = chg_ff;
			`CCL_CMD_INP1: rd_word = inp1_ff;
			`CCL_CMD_INP2: rd_word = inp2_ff;
			default:       rd_word = 16'h0000;
		endcase
	end

	// Protocol next state; data changes only after a clock fall, so our
	// own drive never fakes a start or stop
	always_comb begin
		nxt_st     = st_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_sh     = sh_ff;
		nxt_cmd    = cmd_ff;
		nxt_lo     = lo_ff;
		nxt_rw     = rw_ff;
		nxt_oe     = oe_ff;
		wr_stb     = 1'b0;
		wr_word    = {sh_ff, lo_ff}; // Low byte arrives first
		if (bus_start) begin
			// Start or repeated start always wins
			nxt_st     = st_addr;
			nxt_bitcnt = 4'h0;
			nxt_oe     = 1'b0;
		end else if (bus_stop) begin
			nxt_st = st_idle;
			nxt_oe = 1'b0;
		end else begin
			case (st_ff)
				// Receiving bytes
				st_addr, st_cmd, st_wlo, st_whi: begin
					if (scl_rise) begin
						nxt_sh     = {sh_ff[6:0], sda_lvl};
						nxt_bitcnt = bitcnt_ff + 4'h1;
					end else if (scl_fall && bitcnt_ff == 4'h8) begin
						nxt_oe = 1'b1;
						case (st_ff)
							st_addr: begin
								if (sh_ff[7:1] == `CCL_SMB_ADDR) begin
									nxt_rw = sh_ff[0];
									nxt_st = st_ack_addr;
								end else begin
									nxt_oe = 1'b0; // Not ours: stay silent
									nxt_st = st_idle;
								end
							end
							st_cmd: begin
								nxt_cmd = sh_ff;
								nxt_st  = st_ack_cmd;
							end
							st_wlo: begin
								nxt_lo = sh_ff;
								nxt_st = st_ack_wlo;
							end
							default: begin
								wr_stb = 1'b1;
								nxt_st = st_ack_whi;
							end
						endcase
					end
				end
				// Our acknowledge bit ends at the next clock fall
				st_ack_addr, st_ack_cmd, st_ack_wlo, st_ack_whi: begin
					if (scl_fall) begin
						nxt_bitcnt = 4'h0;
						nxt_oe     = 1'b0;
						case (st_ff)
							st_ack_addr: begin
								if (rw_ff) begin
									nxt_sh = rd_word[7:0];
									nxt_oe = ~rd_word[7];
									nxt_st = st_rlo;
								end else begin
									nxt_st = st_cmd;
								end
							end
							st_ack_cmd: nxt_st = st_wlo;
							st_ack_wlo: nxt_st = st_whi;
							default:    nxt_st = st_idle; // Extra bytes ignored
						endcase
					end
				end
				// Sending bytes, most significant bit first
				st_rlo, st_rhi: begin
					if (scl_fall) begin
						if (bitcnt_ff == 4'h7) begin
							nxt_oe = 1'b0;
							nxt_st = (st_ff == st_rlo) ? st_mack_lo : st_mack_hi;
						end else begin
							nxt_sh     = {sh_ff[6:0], 1'b0};
							nxt_oe     = ~sh_ff[6];
							nxt_bitcnt = bitcnt_ff + 4'h1;
						end
					end
				end
				// Host acknowledge after the low byte decides on the high byte
				st_mack_lo: begin
					if (scl_rise) begin
						nxt_sh[0] = sda_lvl;
					end else if (scl_fall) begin
						if (!sh_ff[0]) begin
							nxt_sh     = rd_word[15:8];
							nxt_oe     = ~rd_word[15];
							nxt_bitcnt = 4'h0;
							nxt_st     = st_rhi;
						end else begin
							nxt_st = st_idle;
						end
					end
				end
				st_mack_hi: begin
					if (scl_fall) begin
						nxt_st = st_idle;
					end
				end
				default: begin
					nxt_oe = 1'b0;
				end
			endcase
		end
	end

	// Protocol registers
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			st_ff     <= st_idle;
			bitcnt_ff <= 4'h0;
			sh_ff     <= 8'h00;
			cmd_ff    <= 8'h00;
			lo_ff     <= 8'h00;
			rw_ff     <= 1'b0;
			oe_ff     <= 1'b0;
			sdo_ff    <= 1'b0;
		end else begin
			st_ff     <= nxt_st;
			bitcnt_ff <= nxt_bitcnt;
			sh_ff     <= nxt_sh;
			cmd_ff    <= nxt_cmd;
			lo_ff     <= nxt_lo;
			rw_ff     <= nxt_rw;
			oe_ff     <= nxt_oe;
			sdo_ff    <= 1'b0; // Open drain: only ever pulls low
		end
	end

	// ------------------------------------------------------------------
	// Ceiling registers
	// ------------------------------------------------------------------
	// Adapter reset beats a same-cycle host write to the primary, and to the secondary unless battery first
	always_comb begin
		nxt_chg  = chg_ff;
		nxt_inp1 = inp1_ff;
		nxt_inp2 = inp2_ff;
		if (wr_stb) begin
			case (cmd_ff)
				`CCL_CMD_CHG:  nxt_chg  = ccl_fold(wr_word);
				`CCL_CMD_INP1: nxt_inp1 = ccl_fold(wr_word);
				`CCL_CMD_INP2: nxt_inp2 = ccl_fold(wr_word);
				default:       nxt_chg  = chg_ff;            // Unmapped write dropped
			endcase
		end
		if (adp_evt) begin
			nxt_inp1 = ccl_fold({3'b000, strap_code, 2'b00});
			if (!pins.lvl[`CCL_IX_BATF]) begin
				nxt_inp2 = `CCL_INP2_DFLT;
			end
		end
	end

	// Ceiling registers and the current outputs derived from them
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			chg_ff               <= `CCL_CHG_RST;
			inp1_ff              <= `CCL_INP1_RST;
			inp2_ff              <= `CCL_INP2_DFLT;
			charge_ma_o          <= 14'h0000;
			input_primary_ma_o   <= 14'h0000;
			input_secondary_ma_o <= 14'h0000;
		end else begin
			chg_ff               <= nxt_chg;
			inp1_ff              <= nxt_inp1;
			inp2_ff              <= nxt_inp2;
			charge_ma_o          <= ccl_ma(chg_ff, pins.lvl[`CCL_IX_CHALF]);
			input_primary_ma_o   <= ccl_ma(inp1_ff, pins.lvl[`CCL_IX_IHALF]);
			input_secondary_ma_o <= ccl_ma(inp2_ff, pins.lvl[`CCL_IX_IHALF]);
		end
	end

	assign sda_o                  = sdo_ff;
	assign sda_oe_o               = oe_ff;
	assign charge_code_o          = chg_ff[12:2];
	assign input_primary_code_o   = inp1_ff[12:2];
	assign input_secondary_code_o = inp2_ff[12:2];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_chg_field_clamp: assert property (
		((chg_ff & ~`CCL_FIELD_MASK) == 16'h0000) && (chg_ff <= `CCL_CEIL_MAX))
		else $error("charge ceiling outside field or clamp");
	a_inp_field_same: assert property (
		((inp1_ff | inp2_ff) & ~`CCL_FIELD_MASK) == 16'h0000
		&& inp1_ff <= `CCL_CEIL_MAX && inp2_ff <= `CCL_CEIL_MAX)
		else $error("input ceiling outside field or clamp");
	a_chg_reset_zero: assert property (
		$rose(nrst_i) |-> chg_ff == 16'h0000)
		else $error("charge ceiling not zero after reset");
	a_chg_write_fold: assert property (
		wr_stb && cmd_ff == `CCL_CMD_CHG |=> chg_ff == ccl_fold($past(wr_word)))
		else $error("charge write not masked and clamped");
	a_strap_load: assert property (
		adp_evt |=> inp1_ff == ccl_fold({3'b000, $past(strap_code), 2'b00}))
		else $error("primary not loaded from strap");
	a_sec_default: assert property (
		adp_evt && !pins.lvl[`CCL_IX_BATF] |=> inp2_ff == `CCL_INP2_DFLT)
		else $error("secondary not defaulted");
	a_sec_kept: assert property (
		adp_evt && pins.lvl[`CCL_IX_BATF] && !wr_stb |=> $stable(inp2_ff))
		else $error("secondary lost with battery first");
	a_ma_weight: assert property (
		##1 charge_ma_o == ($past(pins.lvl[`CCL_IX_CHALF])
			? {$past(chg_ff[12:0]), 1'b0} : {1'b0, $past(chg_ff[12:0])}))
		else $error("charge current weight wrong");
	a_addr_ignore: assert property (
		st_ff == st_addr && scl_fall && bitcnt_ff == 4'h8 && !bus_start && !bus_stop
		&& sh_ff[7:1] != `CCL_SMB_ADDR |=> !oe_ff [*2])
		else $error("acked a foreign address");
	a_read_lo_byte: assert property (
		st_ff == st_ack_addr && rw_ff && scl_fall && !bus_start && !bus_stop
		|=> st_ff == st_rlo && sh_ff == $past(rd_word[7:0]) && oe_ff == ~sh_ff[7])
		else $error("read low byte not loaded");

	c_write_chg:  cover property (wr_stb && cmd_ff == `CCL_CMD_CHG);
	c_read_hi:    cover property (st_ff == st_mack_lo ##[1:1000] st_ff == st_rhi);
	c_adp_reset:  cover property (adp_evt);
	c_clamp_hit:  cover property (wr_stb && ccl_fold(wr_word) == `CCL_CEIL_MAX);
endmodule : ccl_ceiling_regs

// *** ccl_host_model.sv ***
// ----------------------------------------------------------------------
// Serial bus host that issues word writes and word reads
// ----------------------------------------------------------------------
module ccl_host_model
	import ccl_pkg::*;
#(
	parameter int Q = 8 // Clock cycles per quarter bit
) (
	input  wire logic clock_i, // System clock
	input  wire logic sda_i,   // Resolved data wire
	output logic      scl_o,   // Bus clock, high when idle
	output logic      sda_o    // Host data, 1 = released
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero: both lines released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Quarter-bit wait; the bus clock only moves inside frames
	task automatic w;
		repeat (Q) @(posedge clock_i);
	endtask : w

	// Start or repeated start, data falls while the clock is high
	task automatic start_c;
		sda_o <= 1'b1;
		w();
		scl_o <= 1'b1;
		w();
		sda_o <= 1'b0;
		w();
		scl_o <= 1'b0;
		w();
	endtask : start_c

	// Stop, data rises while the clock is high
	task automatic stop_c;
		sda_o <= 1'b0;
		w();
		scl_o <= 1'b1;
		w();
		sda_o <= 1'b1;
		w();
	endtask : stop_c

	// Eight bits MSB first and the ninth acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic [8:0] s;
		logic [8:0] r;
		s = {d, last};
		for (int i = 8; i >= 0; i--) begin
			sda_o <= s[i];
			w();
			scl_o <= 1'b1;
			w();
			// Sampled mid-cycle so the device flop update is never raced
			@(negedge clock_i);
			r[i] = sda_i;
			w();
			scl_o <= 1'b0;
			w();
		end
		q = r[8:1];
		ack = r[0];
	endtask : xfer

	// Word write: address, command, low byte, high byte
	task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
		input ccl_word_t d, output logic nak);
		logic [7:0] q;
		logic       k;
		start_c();
		xfer({a, 1'b0}, 1'b1, q, nak);
		xfer(cmd, 1'b1, q, k);
		nak = nak | k;
		xfer(d[7:0], 1'b1, q, k);
		nak = nak | k;
		xfer(d[15:8], 1'b1, q, k);
		nak = nak | k;
		stop_c();
	endtask : write_word

	// Word read: command, repeated start, low byte acked, high byte nacked
	task automatic read_word(input logic [6:0] a, input logic [7:0] cmd,
		output ccl_word_t d, output logic nak);
		logic [7:0] q;
		logic       k;
		start_c();
		xfer({a, 1'b0}, 1'b1, q, nak);
		xfer(cmd, 1'b1, q, k);
		nak = nak | k;
		start_c();
		xfer({a, 1'b1}, 1'b1, q, k);
		nak = nak | k;
		xfer(8'hff, 1'b0, d[7:0], k);
		xfer(8'hff, 1'b1, d[15:8], k);
		stop_c();
	endtask : read_word
endmodule : ccl_host_model

// *** charge_input_current_limit_regs_bench.sv ***
`include "ccl_consts.svh"

// ----------------------------------------------------------------------
// Bench for the three current ceiling registers
// ----------------------------------------------------------------------
module charge_input_current_limit_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ccl_pkg::*;

	logic        clock;       // 125 MHz system clock
	logic        nrst;        // Synchronous reset, active low
	logic        scl;         // Bus clock from host
	logic        host_sda;    // Host data, 1 = released
	logic        sda_w;       // Resolved open-drain data wire
	logic        sda_val;     // Device data value
	logic        sda_oe;      // Device pulls low when high
	logic        apor;        // Adapter-arrival reset
	logic        batf;        // Battery present first
	logic        chalf;       // Half charge sense resistor
	logic        ihalf;       // Half input sense resistor
	logic [10:0] strap;       // Decoded strap code
	logic [10:0] code[3];     // Stored codes, charge/primary/secondary
	logic [13:0] ma[3];       // mA outputs in the same order
	logic        nak;         // Any missing acknowledge
	ccl_word_t   rdat;        // Read-back word
	int          mismatches;  // Failed comparisons
	int          num_checks;  // All comparisons

	always #4 clock = ~clock;

	// Pull-up wins unless some party drives low
	assign sda_w = host_sda & ~(sda_oe & ~sda_val);

	ccl_ceiling_regs dut (
		.clock_i                   (clock),
		.nrst_i                    (nrst),
		.scl_i                     (scl),
		.sda_i                     (sda_w),
		.sda_o                     (sda_val),
		.sda_oe_o                  (sda_oe),
		.adapter_por_i             (apor),
		.battery_first_i           (batf),
		.charge_half_rsense_i      (chalf),
		.input_half_rsense_i       (ihalf),
		.strap_resistor_pin_code_i (strap),
		.charge_code_o             (code[0]),
		.input_primary_code_o      (code[1]),
		.input_secondary_code_o    (code[2]),
		.charge_ma_o               (ma[0]),
		.input_primary_ma_o        (ma[1]),
		.input_secondary_ma_o      (ma[2])
	);

	ccl_host_model host (
		.clock_i (clock),
		.sda_i   (sda_w),
		.scl_o   (scl),
		.sda_o   (host_sda)
	);

	// ------------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------------
	task automatic chk(input string name, input ccl_word_t exp, input ccl_word_t got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic results;
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// Masking then clamping, worked out independently of the design
	function automatic ccl_word_t fold(input ccl_word_t v);
		fold = v & 16'h1ffc;
		if (fold > 16'h17c0) begin
			fold = 16'h17c0;
		end
	endfunction : fold

	task automatic wr(input logic [7:0] cmd, input ccl_word_t d);
		host.write_word(`CCL_SMB_ADDR, cmd, d, nak);
		chk("write ack", 16'h0000, 16'(nak));
	endtask : wr

	task automatic rd(input logic [7:0] cmd, input ccl_word_t exp);
		host.read_word(`CCL_SMB_ADDR, cmd, rdat, nak);
		chk("read ack", 16'h0000, 16'(nak));
		chk($sformatf("reg %h", cmd), exp, rdat);
	endtask : rd

	// Code and mA outputs of one ceiling; weights double on a half resistor
	task automatic outs(input int k, input ccl_word_t e, input logic half);
		chk($sformatf("code %0d", k), {5'h00, e[12:2]}, {5'h00, code[k]});
		chk($sformatf("ma %0d", k), half ? {2'h0, e[12:0], 1'b0} : {3'h0, e[12:0]},
			{2'h0, ma[k]});
	endtask : outs

	task automatic do_reset;
		nrst <= 1'b0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (10) @(posedge clock);
	endtask : do_reset

	// Release of the adapter reset is the load event
	task automatic adapter_evt(input logic [10:0] s, input logic bf);
		strap <= s;
		batf  <= bf;
		apor  <= 1'b1;
		repeat (10) @(posedge clock);
		apor  <= 1'b0;
		repeat (20) @(posedge clock);
	endtask : adapter_evt

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	logic [7:0] cmds[3] = '{`CCL_CMD_CHG, `CCL_CMD_INP1, `CCL_CMD_INP2};
	ccl_word_t  vals[4] = '{16'hffff, 16'h1237, 16'h0003, 16'h17c4};

	initial begin
		clock = 1'b0;
		nrst  = 1'b0;
		apor  = 1'b0;
		batf  = 1'b0;
		chalf = 1'b0;
		ihalf = 1'b0;
		strap = 11'h000;
		mismatches = 0;
		num_checks = 0;
		do_reset();
		rd(`CCL_CMD_CHG, 16'h0000);
		rd(`CCL_CMD_INP2, 16'h05dc);
		// Foreign address must be refused and change nothing
		host.write_word(7'h0b, `CCL_CMD_CHG, 16'h0100, nak);
		chk("foreign nak", 16'h0001, 16'(nak));
		rd(`CCL_CMD_CHG, 16'h0000);
		// Every ceiling through every masking and clamping corner
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < 4; j++) begin
				chalf <= j[0];
				ihalf <= ~j[0];
				wr(cmds[k], vals[j]);
				rd(cmds[k], fold(vals[j]));
				outs(k, fold(vals[j]), (k == 0) ? j[0] : ~j[0]);
			end
		end
		// Unmapped command reads as zero
		rd(8'h15, 16'h0000);
		// Adapter event without battery first: strap load and default
		adapter_evt(11'h7ff, 1'b0);
		rd(`CCL_CMD_INP1, 16'h17c0);
		rd(`CCL_CMD_INP2, 16'h05dc);
		// Battery first keeps the written secondary value
		wr(`CCL_CMD_INP2, 16'h0100);
		adapter_evt(11'h123, 1'b1);
		rd(`CCL_CMD_INP1, 16'h048c);
		rd(`CCL_CMD_INP2, 16'h0100);
		// Second reset in mid-run clears the charge ceiling again
		wr(`CCL_CMD_CHG, 16'h0800);
		do_reset();
		rd(`CCL_CMD_CHG, 16'h0000);
		outs(0, 16'h0000, chalf);
		rd(`CCL_CMD_INP2, 16'h05dc);
		results();
	end

	// Watchdog sized well above the expected run of about 52000 cycles
	initial begin
		repeat (95000) @(posedge clock);
		mismatches++;
		results();
	end
endmodule : charge_input_current_limit_regs_bench
